// ---- src/odtc_delay.sv ----
`timescale 1ns/1ps
module odtc_delay (
  input  wire logic                       sys_clk,  // core clock
  input  wire logic                       rst_n,    // async reset, low
  input  wire logic                       din,      // bit to delay
  input  wire logic [odtc_pkg::DLY_W-1:0] tap,      // stage selected
  output logic                            dout      // stage tap, delayed
);
  logic [odtc_pkg::DLY_DEPTH-1:0] sr_ff;

  // stage k holds din as sampled k+1 edges ago
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_ff <= '0;
    end else begin
      sr_ff <= {sr_ff[odtc_pkg::DLY_DEPTH-2:0], din};
    end
  end

  assign dout = sr_ff[tap];
endmodule // odtc_delay

// ---- src/odtc_pkg.sv ----
// What this block does
// - termination enabled when any nominal or write strength bit is nonzero
// - enabled: termination follows the registered odt pin; disabled: always off
// - on/off decision uses only the odt pin, never command decode
// - synchronous timing whenever dll runs; precharge power-down keeps it if a12 set
// - synchronous timing: on and off follow the odt sample by the odt latency in cycles
// - odt latency equals cwl plus al minus two
// - dynamic strength switching enabled when either write strength bit is one
// - nominal strength from mr1 a9 a6 a2, write strength from mr2 a10 a9
// - dynamic: any write selects write strength after the switch latency
// - back to nominal after odt latency plus 4 (bc4) or 6 (bl8)
// - self-refresh keeps termination off and ignores odt
// - asynchronous timing does not delay odt by additive latency
package odtc_pkg;
  localparam int unsigned DW         = 16;
  localparam int unsigned AW         = 4;
  localparam int unsigned DLY_W      = 5;
  localparam int unsigned DLY_DEPTH  = 32;
  // register word indices
  localparam logic [3:0] ADDR_MR0    = 4'h0;
  localparam logic [3:0] ADDR_MR1    = 4'h1;
  localparam logic [3:0] ADDR_MR2    = 4'h2;
  localparam logic [3:0] ADDR_STAT   = 4'h3;
  localparam logic [15:0] MR_RST     = 16'h0000;
  // field positions
  localparam int unsigned MR0_PPD_DLL = 12;
  localparam int unsigned MR0_CL_LO   = 4;
  localparam int unsigned MR1_AL_LO   = 3;
  localparam int unsigned MR1_NOM_A2  = 2;
  localparam int unsigned MR1_NOM_A6  = 6;
  localparam int unsigned MR1_NOM_A9  = 9;
  localparam int unsigned MR2_CWL_LO  = 3;
  localparam int unsigned MR2_WR_A9   = 9;
  localparam int unsigned MR2_WR_A10  = 10;
  // latency offsets in cycles
  localparam logic [4:0] CL_BASE     = 5'h04;
  localparam logic [4:0] CWL_BASE    = 5'h05;
  localparam logic [4:0] ODTL_SUB    = 5'h02;
  localparam logic [4:0] ODTH_BC4    = 5'h04;
  localparam logic [4:0] ODTH_BL8    = 5'h06;
  localparam logic [4:0] SYNC_STAGES = 5'h03;
  localparam logic [1:0] AL_ZERO     = 2'h0;
  localparam logic [1:0] AL_CL_M1    = 2'h1;
  localparam logic [1:0] AL_CL_M2    = 2'h2;
endpackage

// ---- src/odtc_sync2.sv ----
`timescale 1ns/1ps
module odtc_sync2 (
  input  wire logic sys_clk,  // core clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic din,      // asynchronous level
  output logic      dout      // synchronised level
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // odtc_sync2

// ---- src/odtc_top.sv ----
`timescale 1ns/1ps
module odtc_top (
  input  wire logic                    sys_clk,     // command clock
  input  wire logic                    rst_n,       // async reset, low
  input  wire logic [odtc_pkg::AW-1:0] reg_addr,    // register word index
  input  wire logic [odtc_pkg::DW-1:0] reg_wdata,   // write data
  input  wire logic                    reg_wr,      // write strobe
  input  wire logic                    reg_rd,      // read strobe
  output logic      [odtc_pkg::DW-1:0] reg_rdata,   // read data, next cycle
  input  wire logic                    odt_pin,     // odt ball
  input  wire logic                    wr_cmd,      // write registered, pulse
  input  wire logic                    wr_bc4,      // write is burst chop 4
  input  wire logic                    self_ref,    // in self-refresh
  input  wire logic                    pd_pre,      // in precharge power-down
  output logic                         rtt_on,      // termination switched on
  output logic                         rtt_is_wr,   // write strength in use
  output logic      [2:0]              rtt_code     // strength code applied
);

  ////////////////////////////////////////////////////////////////////////////
  // mode register images

  logic [odtc_pkg::DW-1:0] mr0_ff;
  logic [odtc_pkg::DW-1:0] mr1_ff;
  logic [odtc_pkg::DW-1:0] mr2_ff;
  logic [odtc_pkg::DW-1:0] rdata_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mr0_ff <= odtc_pkg::MR_RST;
      mr1_ff <= odtc_pkg::MR_RST;
      mr2_ff <= odtc_pkg::MR_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        odtc_pkg::ADDR_MR0: mr0_ff <= reg_wdata;
        odtc_pkg::ADDR_MR1: mr1_ff <= reg_wdata;
        odtc_pkg::ADDR_MR2: mr2_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  logic [2:0] nom_bits;
  logic [1:0] wr_bits;
  logic       odt_enabled;
  logic       dyn_en;
  logic       async_mode;

  assign nom_bits = {mr1_ff[odtc_pkg::MR1_NOM_A9],
                     mr1_ff[odtc_pkg::MR1_NOM_A6],
                     mr1_ff[odtc_pkg::MR1_NOM_A2]};
  assign wr_bits  = {mr2_ff[odtc_pkg::MR2_WR_A10],
                     mr2_ff[odtc_pkg::MR2_WR_A9]};
  assign odt_enabled = (|nom_bits) | (|wr_bits);
  assign dyn_en      = |wr_bits;
  // dll frozen only in precharge power-down with a12 clear
  assign async_mode  = pd_pre & ~mr0_ff[odtc_pkg::MR0_PPD_DLL];

  ////////////////////////////////////////////////////////////////////////////
  // latency arithmetic, all 5-bit cycle counts

  logic [4:0] cl;
  logic [4:0] cwl;
  logic [4:0] al;
  logic [4:0] odtl;
  logic [4:0] odtl_tap;
  logic [4:0] cnw_tap;
  logic [4:0] cwn;

  assign cl  = odtc_pkg::CL_BASE +
               {2'b00, mr0_ff[odtc_pkg::MR0_CL_LO +: 3]};
  assign cwl = odtc_pkg::CWL_BASE +
               {2'b00, mr2_ff[odtc_pkg::MR2_CWL_LO +: 3]};

  always_comb begin
    case (mr1_ff[odtc_pkg::MR1_AL_LO +: 2])
      odtc_pkg::AL_CL_M1: al = cl - 5'h01;
      odtc_pkg::AL_CL_M2: al = cl - 5'h02;
      default:            al = 5'h00;
    endcase
  end

  assign odtl = cwl + al - odtc_pkg::ODTL_SUB;
  // two sync stages and the output flop are part of the latency
  assign odtl_tap = odtl - odtc_pkg::SYNC_STAGES;
  // output flop adds one cycle to the write strength switch
  assign cnw_tap  = odtl - 5'h01;
  assign cwn = odtl + (wr_bc4 ? odtc_pkg::ODTH_BC4
                              : odtc_pkg::ODTH_BL8);

  ////////////////////////////////////////////////////////////////////////////
  // odt pin path

  logic odt_s;
  logic odt_dly;

  odtc_sync2 u_odt_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (odt_pin),
    .dout    (odt_s)
  );

  // the shift register keeps running in every mode so that returning
  // to synchronous timing picks up the true pin history
  odtc_delay u_odt_dly (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (odt_s),
    .tap     (odtl_tap),
    .dout    (odt_dly)
  );

  ////////////////////////////////////////////////////////////////////////////
  // termination on/off

  logic rtt_on_ff;
  logic nxt_rtt_on;

  always_comb begin
    if (self_ref || !odt_enabled) begin
      nxt_rtt_on = 1'b0;
    end else if (async_mode) begin
      nxt_rtt_on = odt_s;
    end else begin
      nxt_rtt_on = odt_dly;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rtt_on_ff <= 1'b0;
    end else begin
      rtt_on_ff <= nxt_rtt_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dynamic strength selection

  logic       wr_start;
  logic       wr_take;
  logic       wr_sel_ff;
  logic [4:0] cwn_cnt_ff;

  assign wr_take = wr_cmd & dyn_en & ~self_ref;

  odtc_delay u_cnw_dly (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (wr_take),
    .tap     (cnw_tap),
    .dout    (wr_start)
  );

  // a later write reloads the count; writes cannot come closer than
  // the burst, so the restart never shortens a window in flight
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cwn_cnt_ff <= 5'h00;
    end else if (wr_take) begin
      cwn_cnt_ff <= cwn;
    end else if (cwn_cnt_ff != 5'h00) begin
      cwn_cnt_ff <= cwn_cnt_ff - 5'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_sel_ff <= 1'b0;
    end else if (!dyn_en || self_ref) begin
      wr_sel_ff <= 1'b0;
    end else if (wr_start) begin
      wr_sel_ff <= 1'b1;
    end else if (cwn_cnt_ff == 5'h01) begin
      wr_sel_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strength code, registered from the select, one cycle after it

  logic [2:0] code_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_ff <= 3'h0;
    end else if (wr_sel_ff) begin
      code_ff <= {1'b0, wr_bits};
    end else begin
      code_ff <= nom_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        odtc_pkg::ADDR_MR0:  rdata_ff <= mr0_ff;
        odtc_pkg::ADDR_MR1:  rdata_ff <= mr1_ff;
        odtc_pkg::ADDR_MR2:  rdata_ff <= mr2_ff;
        odtc_pkg::ADDR_STAT: rdata_ff <= {3'h0, odtl, 3'h0, async_mode,
                                          dyn_en, odt_enabled,
                                          wr_sel_ff, rtt_on_ff};
        default:             rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign rtt_on    = rtt_on_ff;
  assign rtt_is_wr = wr_sel_ff;
  assign rtt_code  = code_ff;

endmodule // odtc_top

// ---- test/odtc_ctl_model.sv ----
`timescale 1ns/1ps
module odtc_ctl_model (
  input  wire logic sys_clk,  // command clock
  input  wire logic go,       // start one odt burst
  input  wire logic do_wr,    // issue a write in the burst
  input  wire logic bc4,      // the write is burst chop 4
  output logic      odt_pin,  // odt ball
  output logic      wr_cmd,   // write command pulse
  output logic      wr_bc4    // burst chop qualifier
);
  logic [3:0] cnt_ff;
  logic [3:0] hold;
  logic       wr_now;
  // hold covers the later of the assertion window and the write window
  assign hold = !do_wr ? 4'h4 : bc4 ? 4'h5 : 4'h7;
  assign wr_now = odt_pin && cnt_ff == 4'h0 && do_wr;
  // no reads are ever issued, so odt never overlaps a read burst
  initial begin
    odt_pin = 1'b0; // odt rests low outside bursts, as dll-off needs
    wr_cmd = 1'b0;
    wr_bc4 = 1'b0;
    cnt_ff = 4'h0;
  end
  always @(posedge sys_clk) begin
    wr_cmd <= wr_now;
    wr_bc4 <= wr_now ? bc4 : !bc4; // meaningless outside a write
    if (go) begin
      odt_pin <= 1'b1;
      cnt_ff <= 4'h0;
    end else if (odt_pin) begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == hold - 4'h1) odt_pin <= 1'b0;
    end
  end
endmodule // odtc_ctl_model

// ---- test/odtc_sva.sv ----
`timescale 1ns/1ps
module odtc_sva (
  input wire logic        sys_clk,   // clock
  input wire logic        rst_n,     // reset, low
  input wire logic [3:0]  reg_addr,  // index
  input wire logic [15:0] reg_wdata, // wdata
  input wire logic        reg_wr,    // write
  input wire logic        odt_pin,   // odt
  input wire logic        wr_cmd,    // write cmd
  input wire logic        wr_bc4,    // bc4
  input wire logic        self_ref,  // self-refresh
  input wire logic        pd_pre,    // power-down
  input wire logic        rtt_on,    // rtt on
  input wire logic        rtt_is_wr, // write rtt
  input wire logic [2:0]  rtt_code   // rtt code
);
  logic [15:0] mr0_ff, mr1_ff, mr2_ff;
  logic [39:0] odh_ff, wrh_ff;
  logic [5:0]  q_ff, lat;
  logic [4:0]  cl, al;
  logic        pd_ff, bc_ff, en, dyn, qt, syn;
  assign cl = 5'(mr0_ff[6:4]) + 5'h04;
  assign al = mr1_ff[4:3] == 2'h1 ? cl - 5'h01 :
              mr1_ff[4:3] == 2'h2 ? cl - 5'h02 : 5'h00;
  assign lat = 6'(5'(mr2_ff[5:3]) + 5'h03 + al); // cwl + al - 2
  assign en = |{mr1_ff[9], mr1_ff[6], mr1_ff[2], mr2_ff[10:9]};
  assign dyn = |mr2_ff[10:9];
  assign syn = !pd_pre || mr0_ff[12];
  // checks wait until config and power state sat still for 40 cycles
  assign qt = q_ff == 6'h28;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {mr0_ff, mr1_ff, mr2_ff} <= '0;
    end else if (reg_wr) begin
      if (reg_addr == 4'h0) mr0_ff <= reg_wdata;
      if (reg_addr == 4'h1) mr1_ff <= reg_wdata;
      if (reg_addr == 4'h2) mr2_ff <= reg_wdata;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {odh_ff, wrh_ff, q_ff, pd_ff, bc_ff} <= '0;
    end else begin
      odh_ff <= {odh_ff[38:0], odt_pin};
      wrh_ff <= {wrh_ff[38:0], wr_cmd};
      pd_ff <= pd_pre;
      if (wr_cmd) bc_ff <= wr_bc4;
      if (reg_wr || self_ref || pd_pre != pd_ff) q_ff <= 6'h00;
      else if (!qt) q_ff <= q_ff + 6'h01;
    end
  end
////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sr_off_a: assert property (self_ref |=> !rtt_on)
    else $error("termination on in self-refresh");
  mr_off_a: assert property (!en |=> !rtt_on)
    else $error("termination on while disabled");
  dyn_off_a: assert property (!dyn |=> !rtt_is_wr)
    else $error("write strength while dynamic off");
  sync_lat_a: assert property (
      qt && en && syn |-> rtt_on == odh_ff[lat])
    else $error("termination edge off its latency");
  async_lat_a: assert property (
      qt && en && !syn |-> rtt_on == odh_ff[2])
    else $error("async termination edge misplaced");
  wr_sel_a: assert property (
      qt && $rose(rtt_is_wr) |-> wrh_ff[lat])
    else $error("write strength start misplaced");
  wr_end_a: assert property (
      qt && $fell(rtt_is_wr) |-> wrh_ff[lat + (bc_ff ? 6'h04 : 6'h06)])
    else $error("write strength end misplaced");
  code_sel_a: assert property (
      qt |-> rtt_code == ($past(rtt_is_wr) ? {1'b0, mr2_ff[10:9]} :
                          {mr1_ff[9], mr1_ff[6], mr1_ff[2]}))
    else $error("strength code wrong");
  cover property (qt && $rose(rtt_on));
  cover property (qt && $fell(rtt_is_wr) && bc_ff);
  cover property (qt && !syn && rtt_on);
endmodule // odtc_sva

// ---- test/odtc_top_test.sv ----
`timescale 1ns/1ps
module odtc_top_test;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, rd;
  logic        self_ref = 1'b0;
  logic        pd_pre = 1'b0;
  logic        go = 1'b0;
  logic        do_wr = 1'b0;
  logic        bc4 = 1'b0;
  logic        odt_pin, wr_cmd, wr_bc4, rtt_on, rtt_is_wr;
  logic [2:0]  rtt_code, code_w;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          dly, on_n, wr_n, lat;
  always #2.5 sys_clk = ~sys_clk;
  odtc_top u_odtc_top (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .odt_pin(odt_pin),
    .wr_cmd(wr_cmd), .wr_bc4(wr_bc4), .self_ref(self_ref),
    .pd_pre(pd_pre), .rtt_on(rtt_on), .rtt_is_wr(rtt_is_wr),
    .rtt_code(rtt_code));
  odtc_ctl_model u_odtc_ctl_model (.sys_clk(sys_clk), .go(go),
    .do_wr(do_wr), .bc4(bc4), .odt_pin(odt_pin), .wr_cmd(wr_cmd),
    .wr_bc4(wr_bc4));
////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // 45 idle cycles let the checker see a settled configuration
  task automatic burst(input logic w, b);
    logic prev;
    prev = 1'b0;
    {dly, on_n, wr_n, code_w} = '0;
    repeat (45) @(posedge sys_clk);
    do_wr <= w;
    bc4 <= b;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (int i = 1; i <= 40; i++) begin
      @(posedge sys_clk);
      #1;
      if (rtt_on === 1'b1 && dly == 0) dly = i;
      if (rtt_on === 1'b1) on_n++;
      if (rtt_is_wr === 1'b1) wr_n++;
      if (prev === 1'b1) code_w = rtt_code;
      prev = rtt_is_wr;
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd_reg(4'(a));
      chk("reset value", a == 3 ? 16'h0300 : 16'h0000, rd);
    end
    burst(1'b0, 1'b0);
    chk("on cycles", 16'h0000, 16'(on_n));
    wr_reg(4'h0, 16'h0020);
    for (int c = 0; c < 2; c++)
      for (int a = 0; a < 4; a++) begin
        lat = 3 + c + (a == 1 ? 5 : a == 2 ? 4 : 0);
        wr_reg(4'h1, 16'h0240 | 16'(a << 3));
        wr_reg(4'h2, 16'(c << 3));
        rd_reg(4'h3);
        chk("status", {3'h0, 5'(lat), 8'h04}, rd);
        burst(1'b0, 1'b0);
        chk("on delay", 16'(lat + 1), 16'(dly));
        chk("on cycles", 16'h0004, 16'(on_n));
      end
    wr_reg(4'h1, 16'h0248);
    wr_reg(4'h2, 16'h0000);
    pd_pre <= 1'b1;
    rd_reg(4'h3);
    chk("async flag", 16'h0010, rd & 16'h0010);
    burst(1'b0, 1'b0);
    chk("async delay", 16'h0003, 16'(dly));
    wr_reg(4'h0, 16'h1020);
    burst(1'b0, 1'b0);
    chk("pd sync delay", 16'h0009, 16'(dly));
    @(posedge sys_clk);
    pd_pre <= 1'b0;
    self_ref <= 1'b1;
    burst(1'b0, 1'b0);
    chk("sr on cycles", 16'h0000, 16'(on_n));
    @(posedge sys_clk);
    self_ref <= 1'b0;
    wr_reg(4'h0, 16'h0020);
    wr_reg(4'h1, 16'h0240);
    wr_reg(4'h2, 16'h0400);
    for (int b = 0; b < 2; b++) begin
      burst(1'b1, 1'(b));
      chk("wr cycles", b ? 16'h0004 : 16'h0006, 16'(wr_n));
      chk("on cycles", b ? 16'h0005 : 16'h0007, 16'(on_n));
      chk("wr code", 16'h0002, 16'(code_w));
      chk("nom code", 16'h0006, 16'(rtt_code));
    end
    wr_reg(4'h2, 16'h0000);
    burst(1'b1, 1'b0);
    chk("wr cycles", 16'h0000, 16'(wr_n));
    wr_reg(4'h3, 16'hffff);
    wr_reg(4'h9, 16'hffff);
    rd_reg(4'h9);
    chk("unmapped", 16'h0000, rd);
    rd_reg(4'h3);
    chk("status", 16'h0304, rd);
    print_verdict;
  end
endmodule // odtc_top_test
bind odtc_top odtc_sva u_odtc_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .odt_pin(odt_pin), .wr_cmd(wr_cmd), .wr_bc4(wr_bc4),
  .self_ref(self_ref), .pd_pre(pd_pre), .rtt_on(rtt_on),
  .rtt_is_wr(rtt_is_wr), .rtt_code(rtt_code));
